// >>> design/capture_engine.sv
// Pre-trigger capture buffer with transform readout and waveform display reduction.
// Assumes samples and trigger come from logic on sys_clk; registers over Avalon-MM.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module capture_engine (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Avalon-MM register slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Sample stream and trigger
   input wire logic sample_valid,
   input wire logic [15:0] sample_data,
   input wire logic trig_in,
   // Transform sample stream
   output logic xfm_valid,
   output logic [15:0] xfm_data,
   input wire logic xfm_ready,
   // Display value stream
   output logic disp_valid,
   output logic [15:0] disp_data,
   input wire logic disp_ready
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [1:0] mode;
      logic [15:0] delay;
      logic [15:0] start;
      logic [10:0] len;
      logic [10:0] step;
      logic [10:0] points;
      logic [10:0] ilimit;
      logic err;
      logic pre_full;
      capture_pkg::cap_state_t cst;
      logic [9:0] wr_ptr;
      logic [9:0] pre_start;
      logic [15:0] skip;
      logic [10:0] fill;
      capture_pkg::xfm_state_t xst;
      logic [9:0] x_addr;
      logic [10:0] x_left;
      logic [15:0] x_data;
      capture_pkg::disp_state_t dst;
      logic [9:0] d_addr;
      logic [10:0] span_left;
      logic [10:0] pts_left;
      logic odd_pt;
      logic first;
      logic [15:0] acc;
      logic [15:0] fifo0;
      logic [15:0] fifo1;
      logic wp;
      logic rp;
      logic [1:0] cnt;
   } state_t;

   state_t s_q, s_d;
   logic [15:0] mem [0:capture_pkg::DEPTH-1];
   logic [15:0] mem_q;
   logic mem_we;
   logic [9:0] rd_addr;

   // Magnitude with saturation so the most negative code stays representable
   function automatic logic [15:0] mag(input logic [15:0] v);
      if (v == capture_pkg::MIN_NEG) begin
         mag = capture_pkg::MAX_POS;
      end else begin
         mag = v[15] ? 16'(-v) : v;
      end
   endfunction

   // Signed start relative to the delay, i.e. offset from the oldest stored sample
   function automatic logic [16:0] rel_off(input logic [15:0] st, input logic [15:0] dl);
      rel_off = 17'({st[15], st} - {dl[15], dl});
   endfunction

   // ---------------------------------------------------------------
   // Buffer memory, one write port for capture and one read port
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         if (mem_we) begin
            mem[s_q.wr_ptr] <= sample_data;
         end
         mem_q <= mem[rd_addr];
      end
   end

   // Readout shares the port; display only runs when no transform is active.
   // The next-state address feeds the port, so the word is ready in the RD cycle.
   assign rd_addr = (s_d.xst != capture_pkg::X_IDLE) ? s_d.x_addr : s_d.d_addr;
   assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
   assign avs_readdata = s_q.rdata;
   assign xfm_valid = (s_q.xst == capture_pkg::X_OUT);
   assign xfm_data = s_q.x_data;
   assign disp_valid = (s_q.cnt != 2'h0);
   assign disp_data = s_q.rp ? s_q.fifo1 : s_q.fifo0;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      logic req;
      logic [16:0] off;
      logic [15:0] pre_n;
      logic eff_near;
      logic bipolar;
      logic push;
      logic pop;
      logic cap_go;
      logic xfm_go;
      logic disp_go;
      s_d = s_q;
      mem_we = 1'b0;
      req = (avs_read | avs_write) & ~s_q.ack;
      off = rel_off(s_q.start, s_q.delay);
      pre_n = 16'(-s_q.delay);
      eff_near = (s_q.mode == capture_pkg::MODE_SAMPLES) ||
         ((s_q.mode == capture_pkg::MODE_INTERP) && (s_q.step <= s_q.ilimit));
      bipolar = (s_q.mode == capture_pkg::MODE_INTERP) && (s_q.step > s_q.ilimit);
      cap_go = 1'b0;
      xfm_go = 1'b0;
      disp_go = 1'b0;
      push = 1'b0;
      pop = 1'b0;

      // Bus slave: one wait cycle, then answer; unmapped reads return zero
      s_d.ack = req;
      if (req && avs_read) begin
         s_d.rdata = 32'h0;
         unique case (avs_address)
            capture_pkg::REG_CTRL: s_d.rdata[capture_pkg::CTRL_MODE_LSB +: 2] = s_q.mode;
            capture_pkg::REG_STATUS: begin
               s_d.rdata[capture_pkg::ST_CAP_BUSY] = (s_q.cst != capture_pkg::C_IDLE) &&
                  (s_q.cst != capture_pkg::C_DONE);
               s_d.rdata[capture_pkg::ST_CAP_DONE] = (s_q.cst == capture_pkg::C_DONE);
               s_d.rdata[capture_pkg::ST_XFM_BUSY] = (s_q.xst != capture_pkg::X_IDLE);
               s_d.rdata[capture_pkg::ST_DISP_BUSY] = (s_q.dst != capture_pkg::D_IDLE);
               s_d.rdata[capture_pkg::ST_RANGE_ERR] = s_q.err;
               s_d.rdata[capture_pkg::ST_PRE_FULL] = s_q.pre_full;
            end
            capture_pkg::REG_DELAY: s_d.rdata[15:0] = s_q.delay;
            capture_pkg::REG_START: s_d.rdata[15:0] = s_q.start;
            capture_pkg::REG_LENGTH: s_d.rdata[10:0] = s_q.len;
            capture_pkg::REG_STEP: s_d.rdata[10:0] = s_q.step;
            capture_pkg::REG_POINTS: s_d.rdata[10:0] = s_q.points;
            capture_pkg::REG_ILIMIT: s_d.rdata[10:0] = s_q.ilimit;
            default: s_d.rdata = 32'h0;
         endcase
      end
      if (req && avs_write) begin
         unique case (avs_address)
            capture_pkg::REG_CTRL: begin
               s_d.mode = avs_writedata[capture_pkg::CTRL_MODE_LSB +: 2];
               cap_go = avs_writedata[capture_pkg::CTRL_CAP_GO];
               xfm_go = avs_writedata[capture_pkg::CTRL_XFM_GO];
               disp_go = avs_writedata[capture_pkg::CTRL_DISP_GO];
            end
            capture_pkg::REG_DELAY: s_d.delay = avs_writedata[15:0];
            capture_pkg::REG_START: s_d.start = avs_writedata[15:0];
            capture_pkg::REG_LENGTH: s_d.len = avs_writedata[10:0];
            capture_pkg::REG_STEP: s_d.step = avs_writedata[10:0];
            capture_pkg::REG_POINTS: s_d.points = avs_writedata[10:0];
            capture_pkg::REG_ILIMIT: s_d.ilimit = avs_writedata[10:0];
            default: ;
         endcase
      end

      // Capture engine; a pre-trigger delay beyond the buffer is refused with the range flag
      unique case (s_q.cst)
         capture_pkg::C_IDLE, capture_pkg::C_DONE: begin
            if (cap_go) begin
               s_d.err = 1'b0;
               s_d.wr_ptr = 10'h0;
               s_d.fill = 11'h0;
               s_d.pre_full = 1'b0;
               if (s_q.delay[15] && (pre_n > 16'(capture_pkg::DEPTH - 1))) begin
                  s_d.err = 1'b1;
               end else if (s_q.delay[15]) begin
                  s_d.cst = capture_pkg::C_PRE;
               end else begin
                  s_d.cst = capture_pkg::C_WAIT;
               end
            end
         end
         capture_pkg::C_PRE: begin
            if (trig_in) begin
               s_d.pre_start = 10'(s_q.wr_ptr - pre_n[9:0]);
               s_d.cst = capture_pkg::C_POST;
            end
            if (sample_valid) begin
               mem_we = 1'b1;
               s_d.wr_ptr = 10'(s_q.wr_ptr + 10'h1);
               if (s_q.fill == 11'(capture_pkg::DEPTH)) begin
                  s_d.pre_full = 1'b1;
               end else begin
                  s_d.fill = 11'(s_q.fill + 11'h1);
               end
            end
         end
         capture_pkg::C_WAIT: begin
            if (trig_in) begin
               s_d.skip = s_q.delay;
               s_d.cst = capture_pkg::C_SKIP;
            end
         end
         capture_pkg::C_SKIP: begin
            if (s_q.skip == 16'h0) begin
               s_d.pre_start = s_q.wr_ptr;
               s_d.cst = capture_pkg::C_POST;
            end else if (sample_valid) begin
               s_d.skip = 16'(s_q.skip - 16'h1);
            end
         end
         capture_pkg::C_POST: begin
            if (sample_valid) begin
               mem_we = 1'b1;
               s_d.wr_ptr = 10'(s_q.wr_ptr + 10'h1);
               if (10'(s_q.wr_ptr + 10'h1) == s_q.pre_start) begin
                  s_d.cst = capture_pkg::C_DONE;
               end
            end
         end
         default: s_d.cst = capture_pkg::C_IDLE;
      endcase

      // Readout start: start is checked against delay and buffer length
      if ((xfm_go || disp_go) && (s_q.xst == capture_pkg::X_IDLE) &&
            (s_q.dst == capture_pkg::D_IDLE)) begin
         if (off[16] || (off[15:0] > 16'(capture_pkg::DEPTH - 1))) begin
            s_d.err = 1'b1;
         end else if (xfm_go && (s_q.len != 11'h0)) begin
            s_d.x_addr = 10'(s_q.pre_start + off[9:0]);
            s_d.x_left = s_q.len;
            s_d.xst = capture_pkg::X_RD;
         end else if (disp_go && (s_q.points != 11'h0)) begin
            s_d.d_addr = 10'(s_q.pre_start + off[9:0]);
            s_d.pts_left = s_q.points;
            s_d.odd_pt = 1'b0;
            s_d.span_left = (s_q.step == 11'h0) ? 11'h1 : s_q.step;
            s_d.first = 1'b1;
            s_d.dst = capture_pkg::D_RD;
         end
      end

      // Transform stream: raw samples, untouched by the display mode
      unique case (s_q.xst)
         capture_pkg::X_IDLE: ;
         capture_pkg::X_RD: s_d.xst = capture_pkg::X_OUT;
         capture_pkg::X_OUT: begin
            // Data register holds while the host stalls
            if (xfm_ready) begin
               s_d.x_addr = 10'(s_q.x_addr + 10'h1);
               s_d.x_left = 11'(s_q.x_left - 11'h1);
               s_d.xst = (s_q.x_left == 11'h1) ? capture_pkg::X_IDLE : capture_pkg::X_RD;
            end
         end
         default: s_d.xst = capture_pkg::X_IDLE;
      endcase
      if (s_q.xst == capture_pkg::X_RD) begin
         s_d.x_data = mem_q;
      end

      // Display reduction: scan one span per plot point
      unique case (s_q.dst)
         capture_pkg::D_IDLE: ;
         capture_pkg::D_RD: s_d.dst = capture_pkg::D_ACC;
         capture_pkg::D_ACC: begin
            if (s_q.first) begin
               // nearest sample is the span head
               s_d.acc = (s_q.mode == capture_pkg::MODE_ABS) ? mag(mem_q) : mem_q;
            end else if (bipolar) begin
               // even points positive peak, odd points negative peak
               if (s_q.odd_pt ? ($signed(mem_q) < $signed(s_q.acc)) :
                     ($signed(mem_q) > $signed(s_q.acc))) begin
                  s_d.acc = mem_q;
               end
            end else if (!eff_near && (mag(mem_q) > mag(s_q.acc))) begin
               s_d.acc = (s_q.mode == capture_pkg::MODE_ABS) ? mag(mem_q) : mem_q;
            end
            s_d.first = 1'b0;
            s_d.d_addr = 10'(s_q.d_addr + 10'h1);
            s_d.span_left = 11'(s_q.span_left - 11'h1);
            s_d.dst = (s_q.span_left == 11'h1) ? capture_pkg::D_PUSH : capture_pkg::D_RD;
         end
         capture_pkg::D_PUSH: begin
            // one value per point, stalled while buffer full
            if (s_q.cnt != 2'h2) begin
               push = 1'b1;
               s_d.odd_pt = ~s_q.odd_pt;
               s_d.pts_left = 11'(s_q.pts_left - 11'h1);
               s_d.span_left = (s_q.step == 11'h0) ? 11'h1 : s_q.step;
               s_d.first = 1'b1;
               s_d.dst = (s_q.pts_left == 11'h1) ? capture_pkg::D_IDLE : capture_pkg::D_RD;
            end
         end
         default: s_d.dst = capture_pkg::D_IDLE;
      endcase

      // Two-entry output buffer so a stalled receiver loses no value
      pop = (s_q.cnt != 2'h0) && disp_ready;
      if (push) begin
         if (s_q.wp) begin
            s_d.fifo1 = s_q.acc;
         end else begin
            s_d.fifo0 = s_q.acc;
         end
         s_d.wp = ~s_q.wp;
      end
      if (pop) begin
         s_d.rp = ~s_q.rp;
      end
      s_d.cnt = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
   end

   // ---------------------------------------------------------------
   // State register; clock enable freezes everything
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.delay <= capture_pkg::DELAY_RST;
         s_q.start <= capture_pkg::START_RST;
         s_q.len <= capture_pkg::LENGTH_RST;
         s_q.step <= capture_pkg::STEP_RST;
         s_q.points <= capture_pkg::POINTS_RST;
         s_q.ilimit <= capture_pkg::ILIMIT_RST;
         s_q.cst <= capture_pkg::C_IDLE;
         s_q.xst <= capture_pkg::X_IDLE;
         s_q.dst <= capture_pkg::D_IDLE;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// >>> design/capture_pkg.sv
// Constants and state types shared by the capture engine and its testbench.
// Assumes a 32-bit Avalon-MM register bus with byte addresses, one word per register.
package capture_pkg;
   // ---------------------------------------------------------------
   // Buffer and sample geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int DEPTH = 1024;
   localparam int SAMPLE_W = 16;
   localparam int CNT_W = 11;
   localparam logic [15:0] MAX_POS = 16'h7fff;
   localparam logic [15:0] MIN_NEG = 16'h8000;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_DELAY = 5'h08;
   localparam logic [4:0] REG_START = 5'h0c;
   localparam logic [4:0] REG_LENGTH = 5'h10;
   localparam logic [4:0] REG_STEP = 5'h14;
   localparam logic [4:0] REG_POINTS = 5'h18;
   localparam logic [4:0] REG_ILIMIT = 5'h1c;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_CAP_GO = 0;
   localparam int CTRL_XFM_GO = 1;
   localparam int CTRL_DISP_GO = 2;
   localparam int CTRL_MODE_LSB = 4;
   localparam int ST_CAP_BUSY = 0;
   localparam int ST_CAP_DONE = 1;
   localparam int ST_XFM_BUSY = 2;
   localparam int ST_DISP_BUSY = 3;
   localparam int ST_RANGE_ERR = 4;
   localparam int ST_PRE_FULL = 5;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [15:0] START_RST = 16'h0000;
   localparam logic [10:0] LENGTH_RST = 11'h400;
   localparam logic [10:0] STEP_RST = 11'h001;
   localparam logic [10:0] POINTS_RST = 11'h001;
   localparam logic [10:0] ILIMIT_RST = 11'h004;

   typedef enum logic [1:0] {MODE_INTERP, MODE_SAMPLES, MODE_PEAK, MODE_ABS} disp_mode_t;
   typedef enum logic [2:0] {C_IDLE, C_PRE, C_WAIT, C_SKIP, C_POST, C_DONE} cap_state_t;
   typedef enum logic [1:0] {X_IDLE, X_RD, X_OUT} xfm_state_t;
   typedef enum logic [1:0] {D_IDLE, D_RD, D_ACC, D_PUSH} disp_state_t;
endpackage

// >>> verification/host_sink.sv
// Host side of one value stream: takes beats and keeps them for the bench.
// Assumes the engine holds valid and data until ready; bench reads got and cnt.
`timescale 1ns/10ps
`default_nettype none
module host_sink (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Stream from the engine
   input wire logic valid,
   input wire logic [15:0] data,
   output logic ready,
   // Bench control
   input wire logic slow,
   input wire logic clr
);
   logic [15:0] got [0:15];
   int cnt;
   int ph;
   // Stall two cycles of three when slow, so a beat must wait in the engine
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready <= 1'b0;
         cnt <= 0;
         ph <= 0;
      end else begin
         ready <= !slow || (ph == 2);
         ph <= (ph == 2) ? 0 : ph + 1;
         if (clr) begin
            cnt <= 0;
         end else if (valid && ready && cnt < 16) begin
            got[cnt] <= data;
            cnt <= cnt + 1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/capture_engine_sva.sv
// Port checker for the capture engine: bus timing, stream holding, readback.
// Assumes one clock; the display mode is shadowed from completed CTRL writes.
`timescale 1ns/10ps
`default_nettype none
module capture_engine_sva (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register bus
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Streams
   input wire logic xfm_valid,
   input wire logic [15:0] xfm_data,
   input wire logic xfm_ready,
   input wire logic disp_valid,
   input wire logic [15:0] disp_data,
   input wire logic disp_ready
);
   logic [1:0] mode_q;
   logic seen_q;
   logic done_rd;
   assign done_rd = avs_read && !avs_waitrequest && avs_address == capture_pkg::REG_CTRL;
   // Shadow of the mode field, valid once software has written it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= 2'h0;
         seen_q <= 1'b0;
      end else if (avs_write && !avs_waitrequest && avs_address == capture_pkg::REG_CTRL) begin
         mode_q <= avs_writedata[5:4];
         seen_q <= 1'b1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus wait longer than one cycle");
   a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest without request");
   a_xfm_hold: assert property (xfm_valid && !xfm_ready |=> xfm_valid && $stable(xfm_data))
      else $error("transform beat dropped");
   a_xfm_gap: assert property (xfm_valid && xfm_ready |=> !xfm_valid)
      else $error("transform beat too early");
   a_disp_hold: assert property (disp_valid && !disp_ready |=> disp_valid && $stable(disp_data))
      else $error("display value dropped");
   a_abs_nonneg: assert property (seen_q && mode_q == 2'h3 && disp_valid |-> !disp_data[15])
      else $error("negative value in absolute mode");
   a_rst_quiet: assert property (!$past(rst_n) |-> !xfm_valid && !disp_valid)
      else $error("stream valid right after reset");
   a_go_readzero: assert property (done_rd |-> avs_readdata[2:0] == 3'h0)
      else $error("go bits read back set");
   a_mode_back: assert property (done_rd && seen_q |-> avs_readdata[5:4] == mode_q)
      else $error("mode readback wrong");
   c_xfm: cover property (xfm_valid && xfm_ready);
   c_abs: cover property (mode_q == 2'h3 && disp_valid && disp_ready);
   c_stall: cover property (disp_valid && !disp_ready);
endmodule
bind capture_engine capture_engine_sva chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .xfm_valid(xfm_valid), .xfm_data(xfm_data),
   .xfm_ready(xfm_ready), .disp_valid(disp_valid), .disp_data(disp_data),
   .disp_ready(disp_ready));
`default_nettype wire

// >>> verification/capture_engine_tb.sv
// Self-checking bench: pre-trigger capture, transform readout, display modes.
// Assumes sample k carries f(k); trigger follows sample 1029, so time zero is 1030.
`timescale 1ns/10ps
`default_nettype none
module capture_engine_tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic sample_valid = 1'b0;
   logic [15:0] sample_data = 16'h0;
   logic trig_in = 1'b0;
   logic xfm_valid, xfm_ready, disp_valid, disp_ready;
   logic [15:0] xfm_data, disp_data;
   logic slow = 1'b1;
   logic clr = 1'b0;
   logic [31:0] q;
   int err_total = 0;
   int compares = 0;
   int k = 0;
   initial forever #50 sys_clk = ~sys_clk;
   capture_engine uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
      .sample_data(sample_data), .trig_in(trig_in), .xfm_valid(xfm_valid),
      .xfm_data(xfm_data), .xfm_ready(xfm_ready), .disp_valid(disp_valid),
      .disp_data(disp_data), .disp_ready(disp_ready));
   host_sink xs (.sys_clk(sys_clk), .rst_n(rst_n), .valid(xfm_valid), .data(xfm_data),
      .ready(xfm_ready), .slow(slow), .clr(clr));
   host_sink ds (.sys_clk(sys_clk), .rst_n(rst_n), .valid(disp_valid), .data(disp_data),
      .ready(disp_ready), .slow(slow), .clr(clr));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic results();
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until the rising edge that sees waitrequest low; data taken there
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (n == 50) begin
         err_total++;
         results();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   function automatic logic [15:0] f(input int s);
      return (s % 3 == 1) ? 16'(-(s * 7)) : 16'(s * 5);
   endfunction
   function automatic logic [15:0] sm(input int i);
      return f(1030 + i);
   endfunction
   function automatic logic [15:0] dexp(input int m, input int s, input int p);
      logic signed [15:0] v, pk, mx, mn;
      int j;
      pk = sm(p * s);
      mx = pk;
      mn = pk;
      for (j = 1; j < s; j++) begin
         v = sm(p * s + j);
         if ((v < 0 ? -v : v) > (pk < 0 ? -pk : pk)) pk = v;
         if (v > mx) mx = v;
         if (v < mn) mn = v;
      end
      if (m == 1 || (m == 0 && s <= 4)) return sm(p * s);
      if (m == 2) return pk;
      if (m == 3) return pk < 0 ? -pk : pk;
      return (p % 2) ? mn : mx;
   endfunction
   task automatic feed(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         sample_valid <= 1'b1;
         sample_data <= f(k);
         k++;
      end
      @(posedge sys_clk);
      sample_valid <= 1'b0;
   endtask
   task automatic run_sink(input logic x, input int n);
      int i;
      for (i = 0; i < 3000; i++) begin
         @(negedge sys_clk);
         if ((x ? xs.cnt : ds.cnt) >= n) break;
      end
      if (i == 3000) begin
         err_total++;
         results();
      end
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      bus(0, capture_pkg::REG_LENGTH, 0);
      check(q, 32'h400);
      bus(0, capture_pkg::REG_ILIMIT, 0);
      check(q, 32'h4);
      bus(0, 5'h02, 0);
      check(q, 32'h0);
   endtask
   task automatic t_capture();
      bus(1, capture_pkg::REG_DELAY, 32'h0000fffc);
      bus(1, capture_pkg::REG_CTRL, 32'h1);
      feed(1030);
      bus(0, capture_pkg::REG_STATUS, 0);
      check(q[capture_pkg::ST_PRE_FULL], 1'b1);
      check(q[1:0], 2'h1);
      @(posedge sys_clk);
      trig_in <= 1'b1;
      @(posedge sys_clk);
      trig_in <= 1'b0;
      feed(1030);
      bus(0, capture_pkg::REG_STATUS, 0);
      check(q[1:0], 2'h2);
   endtask
   task automatic t_xfm();
      int j;
      bus(1, capture_pkg::REG_START, 32'h0000fffc);
      bus(1, capture_pkg::REG_LENGTH, 32'h8);
      bus(1, capture_pkg::REG_CTRL, 32'h32);
      bus(0, capture_pkg::REG_STATUS, 0);
      check(q[capture_pkg::ST_XFM_BUSY], 1'b1);
      run_sink(1'b1, 8);
      for (j = 0; j < 8; j++) check(xs.got[j], sm(j - 4));
      bus(0, capture_pkg::REG_CTRL, 0);
      check(q[5:0], 6'h30);
   endtask
   task automatic t_disp(input int m, input int s);
      int p;
      bus(1, capture_pkg::REG_STEP, 32'(s));
      @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      bus(1, capture_pkg::REG_CTRL, 32'(m * 16 + 4));
      run_sink(1'b0, 4);
      for (p = 0; p < 4; p++) check(ds.got[p], dexp(m, s, p));
   endtask
   task automatic t_range();
      bus(1, capture_pkg::REG_START, 32'h000003fc);
      @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      bus(1, capture_pkg::REG_CTRL, 32'h2);
      repeat (20) @(posedge sys_clk);
      bus(0, capture_pkg::REG_STATUS, 0);
      check(q[capture_pkg::ST_RANGE_ERR], 1'b1);
      check(q[capture_pkg::ST_XFM_BUSY], 1'b0);
      check(32'(xs.cnt), 32'h0);
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_regs();
      t_capture();
      t_xfm();
      bus(1, capture_pkg::REG_START, 32'h0);
      bus(1, capture_pkg::REG_POINTS, 32'h4);
      t_disp(1, 3);
      t_disp(2, 3);
      t_disp(3, 3);
      t_disp(0, 3);
      t_disp(0, 5);
      t_range();
      results();
   end
endmodule
`default_nettype wire
